// [fsk_caller_id_framer.sv]
// Caller-ID FSK message framer with its serial command link.
`include "fsk_framer_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module fsk_caller_id_framer #(
	parameter int BIT_CYCLES = (`BIT_TIME_NS / 1000) * `CORE_CLK_KHZ / 1000
) (
	// Clocks and reset
	input  wire logic       core_clk_i,
	input  wire logic       rst_n_i,
	// Serial command link
	input  wire logic       link_clk_i,
	input  wire logic       link_sel_n_i,
	input  wire logic       link_sdi_i,
	output var  logic       link_sdo_o,
	output var  logic       link_sdo_oe_n_o,
	// Message byte source
	input  wire logic [7:0] byte_i,
	input  wire logic       byte_valid_i,
	output var  logic       byte_req_o,
	// Generator output
	output var  logic       fsk_bit_o,
	output var  logic       fsk_active_o,
	output var  logic [3:0] fsk_chan_en_o,
	output var  logic       std_sel_o
);

	localparam int TW = $clog2(BIT_CYCLES + 1);
	localparam logic [TW-1:0] TMR_LAST = TW'(BIT_CYCLES - 1);

	// ---------------- Link domain ----------------
	logic [4:0]                   lcnt_q, lcnt_d;
	logic [7:0]                   lsh_q, lsh_d;
	logic [7:0]                   lcmd_q, lcmd_d;
	fsk_framer_pkg::link_word_s   lwr_q, lwr_d;
	logic                         wr_tgl_q, wr_tgl_d;
	logic                         rd_tgl_q, rd_tgl_d;
	logic [7:0]                   rd_sh_q, rd_sh_d;
	logic                         sdo_q, sdo_d;
	logic                         sdo_oe_n_q, sdo_oe_n_d;
	logic [2:0]                   ack_s_q;
	logic [7:0]                   in_byte;
	logic                         in_win;

	// Core domain signals read by the link.
	logic                         ack_tgl_q;
	logic [7:0]                   rd_data_q;

	always_comb
	begin
		lcnt_d     = lcnt_q;
		lsh_d      = lsh_q;
		lcmd_d     = lcmd_q;
		lwr_d      = lwr_q;
		wr_tgl_d   = wr_tgl_q;
		rd_tgl_d   = rd_tgl_q;
		rd_sh_d    = rd_sh_q;
		sdo_d      = sdo_q;
		sdo_oe_n_d = 1'b1;
		in_byte    = {lsh_q[6:0], link_sdi_i};
		in_win     = !link_sel_n_i && !lcmd_q[`CMD_WRITE_BIT]
			&& lcnt_q >= `LINK_TURN_END && lcnt_q < `LINK_LAST_BIT;
		// Read data arrives by handshake before the turnaround ends.
		if (ack_s_q[2] != ack_s_q[1])
			rd_sh_d = rd_data_q;
		if (!link_sel_n_i)
		begin
			lsh_d = in_byte;
			lcnt_d = (lcnt_q == `LINK_LAST_BIT) ? 5'h00 : lcnt_q + 5'h01;
			if (lcnt_q == `LINK_CMD_END)
			begin
				lcmd_d = in_byte;
				if (!in_byte[`CMD_WRITE_BIT])
					rd_tgl_d = !rd_tgl_q;
			end
			if (lcnt_q == `LINK_LAST_BIT && lcmd_q[`CMD_WRITE_BIT])
			begin
				lwr_d.cmd  = lcmd_q;
				lwr_d.data = in_byte;
				wr_tgl_d   = !wr_tgl_q;
			end
		end
		if (in_win)
		begin
			sdo_d      = rd_sh_q[7];
			rd_sh_d    = {rd_sh_q[6:0], 1'b0};
			sdo_oe_n_d = 1'b0;
		end
	end

	always_ff @(posedge link_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			lcnt_q     <= 5'h00;
			lsh_q      <= 8'h00;
			lcmd_q     <= 8'h00;
			lwr_q      <= '0;
			wr_tgl_q   <= 1'b0;
			rd_tgl_q   <= 1'b0;
			rd_sh_q    <= 8'h00;
			sdo_q      <= 1'b0;
			sdo_oe_n_q <= 1'b1;
			ack_s_q    <= 3'h0;
		end
		else
		begin
			lcnt_q     <= lcnt_d;
			lsh_q      <= lsh_d;
			lcmd_q     <= lcmd_d;
			lwr_q      <= lwr_d;
			wr_tgl_q   <= wr_tgl_d;
			rd_tgl_q   <= rd_tgl_d;
			rd_sh_q    <= rd_sh_d;
			sdo_q      <= sdo_d;
			sdo_oe_n_q <= sdo_oe_n_d;
			ack_s_q    <= {ack_s_q[1:0], ack_tgl_q};
		end
	end

	assign link_sdo_o      = sdo_q;
	assign link_sdo_oe_n_o = sdo_oe_n_q;

	// ---------------- Core register file ----------------
	logic [2:0] wr_s_q, rd_s_q;
	logic [7:0] flag_q, flag_d, msg_q, msg_d, seize_q, seize_d;
	logic [7:0] mark_q, mark_d, ctrl_q, ctrl_d, rd_data_d;
	logic       ack_tgl_d;
	logic       wr_pulse, rd_pulse, start_clr;

	always_comb
	begin
		wr_pulse  = wr_s_q[2] != wr_s_q[1];
		rd_pulse  = rd_s_q[2] != rd_s_q[1];
		flag_d    = flag_q;
		msg_d     = msg_q;
		seize_d   = seize_q;
		mark_d    = mark_q;
		ctrl_d    = ctrl_q;
		rd_data_d = rd_data_q;
		ack_tgl_d = ack_tgl_q;
		if (start_clr)
			ctrl_d[`CTRL_START_BIT] = 1'b0;
		// Register decode; a host set of start wins over the clear.
		if (wr_pulse)
		begin
			case (lwr_q.cmd)
				`CMD_WR_FLAG:  flag_d  = lwr_q.data;
				`CMD_WR_MSG:   msg_d   = lwr_q.data;
				`CMD_WR_SEIZE: seize_d = lwr_q.data;
				`CMD_WR_MARK:  mark_d  = lwr_q.data;
				`CMD_WR_CTRL:  ctrl_d  = {2'b00, lwr_q.data[5:0]} &
					{7'h7F, lwr_q.data[`CTRL_START_BIT] | !start_clr};
				default:       ;
			endcase
		end
		if (rd_pulse)
		begin
			ack_tgl_d = !ack_tgl_q;
			case (lcmd_q)
				`CMD_RD_FLAG:  rd_data_d = flag_q;
				`CMD_RD_MSG:   rd_data_d = msg_q;
				`CMD_RD_SEIZE: rd_data_d = seize_q;
				`CMD_RD_MARK:  rd_data_d = mark_q;
				`CMD_RD_CTRL:  rd_data_d = ctrl_q;
				default:       rd_data_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			wr_s_q    <= 3'h0;
			rd_s_q    <= 3'h0;
			flag_q    <= `LEN_RESET;
			msg_q     <= `LEN_RESET;
			seize_q   <= `LEN_RESET;
			mark_q    <= `LEN_RESET;
			ctrl_q    <= `CTRL_RESET;
			rd_data_q <= 8'h00;
			ack_tgl_q <= 1'b0;
		end
		else
		begin
			wr_s_q    <= {wr_s_q[1:0], wr_tgl_q};
			rd_s_q    <= {rd_s_q[1:0], rd_tgl_q};
			flag_q    <= flag_d;
			msg_q     <= msg_d;
			seize_q   <= seize_d;
			mark_q    <= mark_d;
			ctrl_q    <= ctrl_d;
			rd_data_q <= rd_data_d;
			ack_tgl_q <= ack_tgl_d;
		end
	end

	// ---------------- Frame sequencer ----------------
	fsk_framer_pkg::frame_state_e st_q, st_d;
	fsk_framer_pkg::frame_len_s   len_q, len_d;
	logic [8:0]    cnt_q, cnt_d;
	logic [6:0]    left_q, left_d;
	logic [7:0]    sh_q, sh_d;
	logic [2:0]    idx_q, idx_d;
	logic [TW-1:0] tmr_q, tmr_d;
	logic          req_q, req_d;
	logic          bit_q, bit_d;
	logic          act_q, act_d;
	logic [3:0]    chan_q, chan_d;
	logic          std_q, std_d;
	logic          tick, all_zero, en, start;

	always_comb
	begin
		en       = ctrl_q[`CTRL_EN_BIT];
		start    = ctrl_q[`CTRL_START_BIT];
		tick     = tmr_q == TMR_LAST;
		all_zero = seize_q == 8'h00 && mark_q == 8'h00 && msg_q == 8'h00;
		st_d      = st_q;
		len_d     = len_q;
		cnt_d     = cnt_q;
		left_d    = left_q;
		sh_d      = sh_q;
		idx_d     = idx_q;
		req_d     = 1'b0;
		start_clr = 1'b0;
		case (st_q)
			fsk_framer_pkg::ST_IDLE:
			begin
				if (en && start)
				begin
					if (all_zero)
						start_clr = 1'b1;
					else
					begin
						len_d.seize_bits = {seize_q, 1'b0};
						len_d.mark_bits  = mark_q;
						len_d.flag_bits  = flag_q;
						left_d = (msg_q > 8'(`MSG_LEN_MAX)) ? `MSG_LEN_MAX
							: msg_q[6:0];
						cnt_d  = 9'h000;
						st_d   = fsk_framer_pkg::ST_SEIZE;
					end
				end
			end
			fsk_framer_pkg::ST_SEIZE:
			begin
				if (cnt_q == len_q.seize_bits)
				begin
					cnt_d = 9'h000;
					st_d  = fsk_framer_pkg::ST_MARK;
				end
				else if (tick)
					cnt_d = cnt_q + 9'h001;
			end
			fsk_framer_pkg::ST_MARK:
			begin
				if (cnt_q[7:0] == len_q.mark_bits)
					st_d = fsk_framer_pkg::ST_FETCH;
				else if (tick)
					cnt_d = cnt_q + 9'h001;
			end
			fsk_framer_pkg::ST_FETCH:
			begin
				// No bytes left ends the frame
				if (left_q == 7'h00)
				begin
					start_clr = 1'b1;
					st_d = ctrl_q[`CTRL_MAS_BIT] ? fsk_framer_pkg::ST_HOLD
						: fsk_framer_pkg::ST_IDLE;
				end
				else if (req_q && byte_valid_i)
				begin
					sh_d   = byte_i;
					idx_d  = 3'h0;
					left_d = left_q - 7'h01;
					st_d   = fsk_framer_pkg::ST_DATA;
				end
				else
					req_d = 1'b1;
			end
			fsk_framer_pkg::ST_DATA:
			begin
				if (tick)
				begin
					sh_d  = {1'b0, sh_q[7:1]};
					idx_d = idx_q + 3'h1;
					if (idx_q == 3'h7 && left_q != 7'h00)
					begin
						cnt_d = 9'h000;
						st_d  = fsk_framer_pkg::ST_FLAG;
					end
					else if (idx_q == 3'h7)
					begin
						start_clr = 1'b1;
						st_d      = ctrl_q[`CTRL_MAS_BIT]
							? fsk_framer_pkg::ST_HOLD : fsk_framer_pkg::ST_IDLE;
					end
				end
			end
			fsk_framer_pkg::ST_FLAG:
			begin
				if (cnt_q[7:0] == len_q.flag_bits)
					st_d = fsk_framer_pkg::ST_FETCH;
				else if (tick)
					cnt_d = cnt_q + 9'h001;
			end
			fsk_framer_pkg::ST_HOLD:
			begin
				if (!ctrl_q[`CTRL_MAS_BIT] && start)
					st_d = fsk_framer_pkg::ST_IDLE;
			end
			default: st_d = fsk_framer_pkg::ST_IDLE;
		endcase
		if (!en)
		begin
			st_d  = fsk_framer_pkg::ST_IDLE;
			req_d = 1'b0;
		end
		tmr_d = (tick || st_d != st_q) ? '0 : tmr_q + TW'(1);
		act_d = st_d != fsk_framer_pkg::ST_IDLE;
		case (st_d)
			// The count at its end shows the mark level, not a stray zero.
			fsk_framer_pkg::ST_SEIZE: bit_d = cnt_d[0]
				|| cnt_d == len_d.seize_bits;
			fsk_framer_pkg::ST_DATA:  bit_d = sh_d[0];
			default:                  bit_d = 1'b1;
		endcase
		chan_d = en ? 4'(4'h1 << ctrl_q[`CTRL_CHAN_MSB:`CTRL_CHAN_LSB])
			: 4'h0;
		std_d = ctrl_q[`CTRL_STD_BIT];
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			st_q   <= fsk_framer_pkg::ST_IDLE;
			len_q  <= '0;
			cnt_q  <= 9'h000;
			left_q <= 7'h00;
			sh_q   <= 8'h00;
			idx_q  <= 3'h0;
			tmr_q  <= '0;
			req_q  <= 1'b0;
			bit_q  <= 1'b1;
			act_q  <= 1'b0;
			chan_q <= 4'h0;
			std_q  <= 1'b0;
		end
		else
		begin
			st_q   <= st_d;
			len_q  <= len_d;
			cnt_q  <= cnt_d;
			left_q <= left_d;
			sh_q   <= sh_d;
			idx_q  <= idx_d;
			tmr_q  <= tmr_d;
			req_q  <= req_d;
			bit_q  <= bit_d;
			act_q  <= act_d;
			chan_q <= chan_d;
			std_q  <= std_d;
		end
	end

	assign byte_req_o    = req_q;
	assign fsk_bit_o     = bit_q;
	assign fsk_active_o  = act_q;
	assign fsk_chan_en_o = chan_q;
	assign std_sel_o     = std_q;

endmodule : fsk_caller_id_framer

`default_nettype wire

// [fsk_caller_id_framer_test.sv]
// Self-checking bench of the caller-ID framer.
`timescale 1ns/100ps
`default_nettype none
module fsk_caller_id_framer_test;
	localparam int BITC = 4;
	logic core_clk_i = 1'b0;
	logic rst_n_i, link_clk_i, link_sel_n_i, link_sdi_i;
	logic link_sdo_o, link_sdo_oe_n_o, byte_valid_i, byte_req_o;
	logic fsk_bit_o, fsk_active_o, std_sel_o;
	logic [7:0] byte_i, rd;
	logic [3:0] fsk_chan_en_o;
	int error_cnt, cmp_count, takes, take_base, n;
	logic runs_v [$];
	logic ev [$];
	int runs_n [$];
	int en [$];
	// Rows: write code, read code, data, expected read back.
	logic [31:0] rows [5] = '{32'hAC2CA5A5, 32'hAD2D4040, 32'hAE2EFFFF,
		32'hAF2F5A5A, 32'hB0303434};
	fsk_caller_id_framer #(.BIT_CYCLES(BITC)) DUT (.*);
	fsk_link_host host (.link_clk_o(link_clk_i), .link_sel_n_o(link_sel_n_i),
		.link_sdi_o(link_sdi_i), .link_sdo_i(link_sdo_o),
		.link_sdo_oe_n_i(link_sdo_oe_n_o));
	always #12.5 core_clk_i = ~core_clk_i;
	// The byte source stalls every other cycle.
	always @(negedge core_clk_i)
	begin
		byte_valid_i <= rst_n_i & ~byte_valid_i;
		byte_i <= 8'h3C + 8'(takes - take_base);
	end
	always @(posedge core_clk_i)
		if (byte_req_o === 1'b1 && byte_valid_i)
			takes <= takes + 1;
	task automatic summarize();
		$display("errors %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : summarize
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic reg_wr(input logic [7:0] cmd, input logic [7:0] data);
		host.xfer(cmd, data, rd);
		repeat (6) @(negedge core_clk_i);
	endtask : reg_wr
	task automatic reg_rd(input logic [7:0] cmd, input logic [7:0] exp);
		host.xfer(cmd, 8'h00, rd);
		check(rd, exp);
	endtask : reg_rd
	task automatic setup(input logic [7:0] f, w, s, m);
		reg_wr(8'hAC, f);
		reg_wr(8'hAD, w);
		reg_wr(8'hAE, s);
		reg_wr(8'hAF, m);
		take_base = takes;
	endtask : setup
	task automatic wait_for(input logic want);
		for (n = 0; fsk_active_o !== want; n++)
		begin
			@(negedge core_clk_i);
			if (n > 5000)
			begin
				check(8'h00, 8'h01);
				summarize();
			end
		end
	endtask : wait_for
	// Output bits are logged as runs of equal value while a frame runs.
	task automatic trace();
		for (n = 0; fsk_active_o === 1'b1 && n < 5000; n++)
		begin
			if (runs_v.size() == 0 || runs_v[$] !== fsk_bit_o)
			begin
				runs_v.push_back(fsk_bit_o);
				runs_n.push_back(0);
			end
			runs_n[$] = runs_n[$] + 1;
			@(negedge core_clk_i);
		end
	endtask : trace
	task automatic add_bits(input logic [7:0] v, input int cnt);
		for (int i = 0; i < cnt; i++)
		begin
			if (ev.size() == 0 || ev[$] !== v[i%8])
			begin
				ev.push_back(v[i%8]);
				en.push_back(0);
			end
			en[$] = en[$] + 1;
		end
	endtask : add_bits
	initial
	begin
		rst_n_i = 1'b0;
		{error_cnt, cmp_count} = '0;
		repeat (2) @(negedge core_clk_i);
		rst_n_i = 1'b1;
		repeat (4) @(negedge core_clk_i);
		for (int i = 0; i < 6; i++)
			reg_rd(8'h2C + 8'(i), 8'h00);
		for (int i = 0; i < 5; i++)
		begin
			reg_wr(rows[i][31:24], rows[i][15:8]);
			reg_rd(rows[i][23:16], rows[i][7:0]);
		end
		check({4'h0, fsk_chan_en_o}, 8'h00);
		for (int c = 0; c < 4; c++)
		begin
			reg_wr(8'hB0, {2'b00, 2'(c), 1'b1, c[0], 2'b00});
			check({4'h0, fsk_chan_en_o}, 8'h01 << c);
			check(8'(std_sel_o), 8'(c[0]));
		end
		setup(8'h00, 8'h00, 8'h00, 8'h00);
		reg_wr(8'hB0, 8'h09);
		reg_rd(8'h30, 8'h08);
		setup(8'h02, 8'h02, 8'h02, 8'h02);
		host.xfer(8'hB0, 8'h09, rd);
		wait_for(1'b1);
		fork
			trace();
			reg_wr(8'hAE, 8'h07);
		join
		add_bits(8'hAA, 4);
		add_bits(8'hFF, 2);
		add_bits(8'h3C, 8);
		add_bits(8'hFF, 2);
		add_bits(8'h3D, 8);
		check(8'(runs_v.size()), 8'(ev.size()));
		for (int i = 0; i < ev.size() && i < runs_v.size(); i++)
		begin
			check(8'(runs_v[i]), 8'(ev[i]));
			check(8'(ev[i] ? runs_n[i] >= BITC * en[i]
				: runs_n[i] == BITC * en[i]), 8'h01);
		end
		check(8'(takes - take_base), 8'h02);
		reg_rd(8'h30, 8'h08);
		setup(8'h00, 8'h50, 8'h00, 8'h00);
		host.xfer(8'hB0, 8'h0B, rd);
		for (int i = 0; i < 4000 && takes - take_base < 64; i++)
			@(negedge core_clk_i);
		repeat (200) @(negedge core_clk_i);
		check(8'(takes - take_base), 8'h40);
		check({fsk_active_o, fsk_bit_o}, 8'h03);
		reg_rd(8'h30, 8'h0A);
		setup(8'h00, 8'h00, 8'h00, 8'h03);
		host.xfer(8'hB0, 8'h09, rd);
		repeat (8) @(negedge core_clk_i);
		wait_for(1'b0);
		check(8'(takes - take_base), 8'h00);
		reg_rd(8'h30, 8'h08);
		host.xfer(8'hB0, 8'h09, rd);
		wait_for(1'b1);
		rst_n_i = 1'b0;
		@(negedge core_clk_i);
		check({fsk_active_o, fsk_chan_en_o}, 8'h00);
		rst_n_i = 1'b1;
		repeat (4) @(negedge core_clk_i);
		reg_rd(8'h2F, 8'h00);
		summarize();
	end
endmodule : fsk_caller_id_framer_test
bind fsk_caller_id_framer fsk_framer_props u_props (.core_clk_i, .rst_n_i,
	.link_clk_i, .link_sel_n_i, .link_sdo_oe_n_o, .byte_valid_i, .byte_req_o,
	.fsk_bit_o, .fsk_active_o, .fsk_chan_en_o, .std_sel_o);
`default_nettype wire

// [fsk_framer_defines.svh]
// Offsets, field positions, reset values and timing counts of the framer.
`ifndef FSK_FRAMER_DEFINES_SVH
`define FSK_FRAMER_DEFINES_SVH

// Command bytes: read code has bit 7 clear, write code has it set.
`define CMD_WRITE_BIT      7
`define CMD_RD_FLAG        8'h2C
`define CMD_RD_MSG         8'h2D
`define CMD_RD_SEIZE       8'h2E
`define CMD_RD_MARK        8'h2F
`define CMD_RD_CTRL        8'h30
`define CMD_WR_FLAG        8'hAC
`define CMD_WR_MSG         8'hAD
`define CMD_WR_SEIZE       8'hAE
`define CMD_WR_MARK        8'hAF
`define CMD_WR_CTRL        8'hB0

// Control byte layout.
`define CTRL_START_BIT     0
`define CTRL_MAS_BIT       1
`define CTRL_STD_BIT       2
`define CTRL_EN_BIT        3
`define CTRL_CHAN_LSB      4
`define CTRL_CHAN_MSB      5

// Reset values and the message length limit.
`define LEN_RESET          8'h00
`define CTRL_RESET         8'h00
`define MSG_LEN_MAX        7'h40

// Link frame: command byte, turnaround byte, data byte.
`define LINK_LAST_BIT      5'h17
`define LINK_CMD_END       5'h07
`define LINK_TURN_END      5'h0F

// Timing.
`define CORE_CLK_KHZ       40000
`define BIT_TIME_NS        833333

`endif

// [fsk_framer_pkg.sv]
// Types shared by the framer.
package fsk_framer_pkg;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_SEIZE = 3'b001,
		ST_MARK  = 3'b010,
		ST_FETCH = 3'b011,
		ST_DATA  = 3'b100,
		ST_FLAG  = 3'b101,
		ST_HOLD  = 3'b110
	} frame_state_e;

	typedef struct packed {
		logic [7:0] cmd;
		logic [7:0] data;
	} link_word_s;

	typedef struct packed {
		logic [8:0] seize_bits;
		logic [7:0] mark_bits;
		logic [7:0] flag_bits;
	} frame_len_s;

endpackage : fsk_framer_pkg

// [fsk_framer_props.sv]
// Port-level checks of the caller-ID framer.
`timescale 1ns/100ps
`default_nettype none
module fsk_framer_props (
	// Clocks and reset
	input wire logic       core_clk_i,
	input wire logic       rst_n_i,
	input wire logic       link_clk_i,
	// Link
	input wire logic       link_sel_n_i,
	input wire logic       link_sdo_oe_n_o,
	// Byte source
	input wire logic       byte_valid_i,
	input wire logic       byte_req_o,
	// Generator
	input wire logic       fsk_bit_o,
	input wire logic       fsk_active_o,
	input wire logic [3:0] fsk_chan_en_o,
	input wire logic       std_sel_o
);
	reset_quiet_a: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i) $rose(rst_n_i) |-> fsk_bit_o && !fsk_active_o
		&& !byte_req_o && fsk_chan_en_o == 4'h0 && !std_sel_o)
		else $error("outputs not quiet after reset");
	chan_onehot_a: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i) $onehot0(fsk_chan_en_o))
		else $error("more than one channel enabled");
	idle_mark_a: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i) !fsk_active_o |-> fsk_bit_o)
		else $error("muted output not at one");
	take_drop_a: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i) byte_req_o && byte_valid_i |=> !byte_req_o)
		else $error("byte request held after take");
	req_in_frame_a: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i) byte_req_o |-> fsk_active_o)
		else $error("byte request outside a frame");
	bit_hold_a: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i) $fell(fsk_bit_o) && fsk_active_o |=>
		(!fsk_bit_o || !fsk_active_o)[*3])
		else $error("zero bit shorter than four cycles");
	start_enabled_a: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i) $rose(fsk_active_o) |-> fsk_chan_en_o != 4'h0)
		else $error("frame began with generator off");
	read_window_a: assert property (@(posedge link_clk_i)
		disable iff (!rst_n_i) $fell(link_sdo_oe_n_o) |->
		(!link_sdo_oe_n_o)[*8] ##1 link_sdo_oe_n_o)
		else $error("read drive not eight bits");
	drive_sel_a: assert property (@(posedge link_clk_i)
		disable iff (!rst_n_i) !link_sdo_oe_n_o |-> !link_sel_n_i)
		else $error("drive while not selected");
	cover property (@(posedge core_clk_i) $rose(fsk_active_o));
	cover property (@(posedge core_clk_i) byte_req_o && byte_valid_i);
	cover property (@(posedge link_clk_i) $fell(link_sdo_oe_n_o));
endmodule : fsk_framer_props
`default_nettype wire

// [fsk_link_host.sv]
// Host model that drives the serial command link.
`timescale 1ns/100ps
`default_nettype none
module fsk_link_host (
	// Link pins
	output var logic link_clk_o,
	output var logic link_sel_n_o,
	output var logic link_sdi_o,
	input wire logic link_sdo_i,
	input wire logic link_sdo_oe_n_i
);
	// Two link edges fall inside the opening reset, then the clock stops.
	initial
	begin
		link_sel_n_o = 1'b1;
		link_sdi_o = 1'b0;
		link_clk_o = 1'b0;
		repeat (2)
		begin
			#15 link_clk_o = 1'b1;
			#15 link_clk_o = 1'b0;
		end
	end
	task automatic xfer(input logic [7:0] cmd, input logic [7:0] data,
		output logic [7:0] rd);
		link_sel_n_o = 1'b0;
		for (int i = 0; i < 24; i++)
		begin
			link_sdi_o = i < 8 ? cmd[7-i] : i < 16 ? ~link_sdi_o : data[23-i];
			#15;
			if (i >= 16)
				rd[23-i] = link_sdo_oe_n_i ? ~link_sdo_i : link_sdo_i;
			link_clk_o = 1'b1;
			#15 link_clk_o = 1'b0;
		end
		link_sel_n_o = 1'b1;
		link_sdi_o = ~link_sdi_o;
		#15;
	endtask : xfer
endmodule : fsk_link_host
`default_nettype wire
